// [core/sfr_map.svh]
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// Read opcodes and the four-byte mode enter/exit opcodes
`define SFR_OP_SFDP       8'h5A
`define SFR_OP_READ3      8'h03
`define SFR_OP_READ4      8'h13
`define SFR_OP_FAST3      8'h0B
`define SFR_OP_FAST4      8'h0C
`define SFR_OP_OOUT3      8'h8B
`define SFR_OP_OOUT4      8'h7C
`define SFR_OP_OIO3       8'hCB
`define SFR_OP_OIO4       8'hCC
`define SFR_OP_DDR_OOUT   8'h9D
`define SFR_OP_DDR_OIO    8'hFD
`define SFR_OP_ENTER4     8'hB7
`define SFR_OP_EXIT4      8'hE9

// Address lengths in bits
`define SFR_ABITS3        6'h18
`define SFR_ABITS4        6'h20

// Dummy clocks of the discovery-table read
`define SFR_SFDP_DUMMY    6'h08

// Serial command length, one bit per rising edge
`define SFR_CMD_BITS      6'h08

// Output enables, active low per line
`define SFR_OE_OFF        8'hFF
`define SFR_OE_LINE1      8'hFD
`define SFR_OE_ALL        8'h00

// Array address width, 128 Mbyte
`define SFR_ARRAY_AW      27

`endif

// [core/sfr_pkg.sv]
package sfr_pkg;

    typedef enum logic [5:0] {
        SFR_IDLE   = 6'h01,
        SFR_CMD    = 6'h02,
        SFR_DECODE = 6'h04,
        SFR_ADDR   = 6'h08,
        SFR_DUMMY  = 6'h10,
        SFR_DATA   = 6'h20
    } sfr_state_e;

    typedef enum logic [2:0] {
        SFR_DUM_NONE  = 3'h1,
        SFR_DUM_CFG   = 3'h2,
        SFR_DUM_EIGHT = 3'h4
    } sfr_dummy_e;

endpackage : sfr_pkg

// [core/sfr_in_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module sfr_in_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // A bit changes only once the second and third stages agree
    always_comb
    begin
        nxt_q = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q_ff  <= RST_VAL;
        end
        else
        begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign sync_o = q_ff;

endmodule : sfr_in_sync

`default_nettype wire

// [core/sfr_cmd_decode.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map.svh"

module sfr_cmd_decode (
    input  wire logic             opcode_i,
    input  wire logic [7:0]       op_i,
    input  wire logic             addr4_i,
    input  wire logic             octal_ddr_i,
    output logic                  valid_o,
    output logic                  sfdp_o,
    output logic                  enter4_o,
    output logic                  exit4_o,
    output logic      [5:0]       abits_o,
    output logic                  a8_o,
    output logic                  addr_ddr_o,
    output logic                  d8_o,
    output logic                  data_ddr_o,
    output sfr_pkg::sfr_dummy_e   dummy_o
);

    logic [5:0] abits_cfg;

    always_comb
    begin
        abits_cfg  = addr4_i ? `SFR_ABITS4 : `SFR_ABITS3; // RQ19
        valid_o    = opcode_i;
        sfdp_o     = 1'b0;
        enter4_o   = 1'b0;
        exit4_o    = 1'b0;
        abits_o    = abits_cfg;
        a8_o       = 1'b0;
        addr_ddr_o = 1'b0;
        d8_o       = 1'b0;
        data_ddr_o = 1'b0;
        dummy_o    = sfr_pkg::SFR_DUM_CFG;
        case (op_i)
            `SFR_OP_SFDP:
            begin
                sfdp_o  = 1'b1;
                abits_o = `SFR_ABITS3; // RQ21
                dummy_o = sfr_pkg::SFR_DUM_EIGHT; // RQ1
            end
            `SFR_OP_READ3:
            begin
                dummy_o = sfr_pkg::SFR_DUM_NONE; // RQ5
            end
            `SFR_OP_READ4:
            begin
                abits_o = `SFR_ABITS4; // RQ16
                dummy_o = sfr_pkg::SFR_DUM_NONE;
            end
            // Basic read plus the configured dummy clocks; no rate limit lives in this logic
            `SFR_OP_FAST3:
            begin
                abits_o = abits_cfg; // RQ6
            end
            `SFR_OP_FAST4:
            begin
                abits_o = `SFR_ABITS4; // RQ16
            end
            `SFR_OP_OOUT3:
            begin
                d8_o = 1'b1; // RQ7
            end
            `SFR_OP_OOUT4:
            begin
                abits_o = `SFR_ABITS4; // RQ16
                d8_o    = 1'b1;
            end
            `SFR_OP_OIO3:
            begin
                a8_o = 1'b1; // RQ8
                d8_o = 1'b1;
            end
            `SFR_OP_OIO4:
            begin
                abits_o = `SFR_ABITS4; // RQ16
                a8_o    = 1'b1;
                d8_o    = 1'b1;
            end
            `SFR_OP_DDR_OOUT:
            begin
                addr_ddr_o = 1'b1; // RQ9
                d8_o       = 1'b1;
                data_ddr_o = 1'b1; // RQ13
            end
            `SFR_OP_DDR_OIO:
            begin
                abits_o    = `SFR_ABITS4; // RQ18
                a8_o       = 1'b1;
                addr_ddr_o = 1'b1;
                d8_o       = 1'b1;
                data_ddr_o = 1'b1;
            end
            `SFR_OP_ENTER4:
            begin
                valid_o  = 1'b0;
                enter4_o = opcode_i; // RQ17
            end
            `SFR_OP_EXIT4:
            begin
                valid_o = 1'b0;
                exit4_o = opcode_i; // RQ17
            end
            default:
            begin
                valid_o = 1'b0;
            end
        endcase
        // Full octal double-rate protocol: every phase on eight lines, both edges
        if (octal_ddr_i)
        begin
            abits_o    = `SFR_ABITS4; // RQ20
            a8_o       = 1'b1;
            addr_ddr_o = 1'b1;
            d8_o       = 1'b1;
            data_ddr_o = 1'b1; // RQ13
        end
    end

endmodule : sfr_cmd_decode

`default_nettype wire

// [core/sfr_read_path.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map.svh"

// Operation
// RQ1: Discovery read: command, 3 address bytes, 8 dummies
// RQ2: Discovery read wraps at 256 bytes to zero
// RQ3: Discovery read ignores burst wrap setting
// RQ4: Chip select high ends read, stop driving
// RQ5: Basic read: single line, 24-bit address
// RQ6: Fast read single line, usable at fast clock
// RQ7: Octal output read: serial in, eight-line data
// RQ8: Octal I/O read: eight-line address and data
// RQ9: Double-rate octal output: DDR address, DDR data
// RQ10: Address increments after each data byte
// RQ11: Address wraps past array end to zero
// RQ12: Address bits sampled on serial clock rise
// RQ13: DDR opcodes always DDR, others when configured
// RQ14: Double-rate transfers an even byte count
// RQ15: Host gives even byte address in DDR
// RQ16: Four-byte variants take a 32-bit address
// RQ17: Address length from config or enter/exit commands
// RQ18: DDR octal I/O read: always 32-bit address
// RQ19: Octal reads use 32 bits in four-byte mode
// RQ20: Octal DDR protocol: all phases, 4-byte address
// RQ21: Discovery read 3-byte unless octal DDR
// RQ22: Dummy clocks inserted with lines undriven
module sfr_read_path (
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      sclk_i,
    input  wire logic                      cs_n_i,
    input  wire logic [7:0]                serial_io_lines_i,
    output logic      [7:0]                serial_io_lines_o,
    output logic      [7:0]                serial_io_lines_oe_n_o,
    input  wire logic                      cfg_nv_addr4_i,
    input  wire logic                      cfg_octal_ddr_i,
    input  wire logic [4:0]                cfg_dummy_i,
    output logic      [`SFR_ARRAY_AW-1:0]  rd_addr_o,
    output logic                           rd_sfdp_o,
    input  wire logic [7:0]                rd_data_i,
    output logic                           addr4_mode_o
);

    logic [9:0]                 pins_q;
    logic                       sclk_q;
    logic                       cs_q;
    logic [7:0]                 dq_q;
    logic                       rise;
    logic                       fall;

    sfr_pkg::sfr_state_e        state_ff;
    sfr_pkg::sfr_state_e        nxt_state;
    logic                       sclk_d_ff;
    logic                       nxt_sclk_d;
    logic [7:0]                 op_ff;
    logic [7:0]                 nxt_op;
    logic [5:0]                 cnt_ff;
    logic [5:0]                 nxt_cnt;
    logic [31:0]                addr_sr_ff;
    logic [31:0]                nxt_addr_sr;
    logic [7:0]                 out_sr_ff;
    logic [7:0]                 nxt_out_sr;
    logic [2:0]                 bit_ff;
    logic [2:0]                 nxt_bit;
    logic [7:0]                 dq_ff;
    logic [7:0]                 nxt_dq;
    logic [7:0]                 oe_n_ff;
    logic [7:0]                 nxt_oe_n;
    logic [`SFR_ARRAY_AW-1:0]   rd_addr_ff;
    logic [`SFR_ARRAY_AW-1:0]   nxt_rd_addr;
    logic                       rd_sfdp_ff;
    logic                       nxt_rd_sfdp;
    logic                       addr4_ff;
    logic                       nxt_addr4;
    logic                       init_ff;
    logic                       nxt_init;

    logic                       dec_valid;
    logic                       dec_sfdp;
    logic                       dec_enter4;
    logic                       dec_exit4;
    logic [5:0]                 dec_abits;
    logic                       dec_a8;
    logic                       dec_addr_ddr;
    logic                       dec_d8;
    logic                       dec_data_ddr;
    sfr_pkg::sfr_dummy_e        dec_dummy;

    logic [31:0]                a_next;
    logic [5:0]                 a_cnt;
    logic [5:0]                 dummy_need;
    logic [7:0]                 cur_byte;
    logic                       adv;

    function automatic logic [5:0] sfr_step(input logic lanes8);
        sfr_step = lanes8 ? 6'h08 : 6'h01;
    endfunction : sfr_step

    // Serial clock, select and data share one pipeline so they stay aligned
    sfr_in_sync #(
        .W       (10),
        .RST_VAL (10'h200)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({cs_n_i, sclk_i, serial_io_lines_i}),
        .sync_o     (pins_q)
    );

    assign cs_q   = pins_q[9];
    assign sclk_q = pins_q[8];
    assign dq_q   = pins_q[7:0];
    assign rise   = sclk_q & ~sclk_d_ff;
    assign fall   = ~sclk_q & sclk_d_ff;

    sfr_cmd_decode u_dec (
        .opcode_i    (state_ff == sfr_pkg::SFR_DECODE),
        .op_i        (op_ff),
        .addr4_i     (addr4_ff),
        .octal_ddr_i (cfg_octal_ddr_i),
        .valid_o     (dec_valid),
        .sfdp_o      (dec_sfdp),
        .enter4_o    (dec_enter4),
        .exit4_o     (dec_exit4),
        .abits_o     (dec_abits),
        .a8_o        (dec_a8),
        .addr_ddr_o  (dec_addr_ddr),
        .d8_o        (dec_d8),
        .data_ddr_o  (dec_data_ddr),
        .dummy_o     (dec_dummy)
    );

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_sclk_d  = sclk_q;
        nxt_op      = op_ff;
        nxt_cnt     = cnt_ff;
        nxt_addr_sr = addr_sr_ff;
        nxt_out_sr  = out_sr_ff;
        nxt_bit     = bit_ff;
        nxt_dq      = dq_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_rd_sfdp = rd_sfdp_ff;
        nxt_addr4   = addr4_ff;
        nxt_init    = init_ff;
        adv         = 1'b0;
        a_next      = dec_a8 ? {addr_sr_ff[23:0], dq_q} : {addr_sr_ff[30:0], dq_q[0]};
        a_cnt       = cnt_ff + sfr_step(dec_a8);
        cur_byte    = (bit_ff == 3'h0) ? rd_data_i : out_sr_ff;
        case (dec_dummy)
            sfr_pkg::SFR_DUM_EIGHT: dummy_need = `SFR_SFDP_DUMMY;
            sfr_pkg::SFR_DUM_CFG:   dummy_need = {1'b0, cfg_dummy_i};
            default:                dummy_need = 6'h00;
        endcase
        // Nonvolatile address length is taken once, after reset releases
        if (!init_ff)
        begin
            nxt_addr4 = cfg_nv_addr4_i; // RQ17
            nxt_init  = 1'b1;
        end
        if (cs_q)
        begin
            nxt_state = sfr_pkg::SFR_IDLE; // RQ4
            nxt_oe_n  = `SFR_OE_OFF; // RQ4
            nxt_dq    = 8'h00;
        end
        else
        begin
            case (state_ff)
                sfr_pkg::SFR_IDLE:
                begin
                    nxt_state = sfr_pkg::SFR_CMD;
                    nxt_cnt   = 6'h00;
                    nxt_op    = 8'h00;
                end
                sfr_pkg::SFR_CMD:
                begin
                    if (cfg_octal_ddr_i)
                    begin
                        // Opcode byte on the first edge, its companion byte on the second
                        if (rise || fall)
                        begin
                            if (cnt_ff == 6'h00)
                            begin
                                nxt_op = dq_q; // RQ20
                            end
                            nxt_cnt = cnt_ff + 6'h01;
                            if (cnt_ff == 6'h01)
                            begin
                                nxt_state = sfr_pkg::SFR_DECODE;
                            end
                        end
                    end
                    else if (rise)
                    begin
                        nxt_op  = {op_ff[6:0], dq_q[0]}; // RQ1 RQ5
                        nxt_cnt = cnt_ff + 6'h01;
                        if (cnt_ff == `SFR_CMD_BITS - 6'h01)
                        begin
                            nxt_state = sfr_pkg::SFR_DECODE;
                        end
                    end
                end
                sfr_pkg::SFR_DECODE:
                begin
                    nxt_cnt     = 6'h00;
                    nxt_addr_sr = 32'h0000_0000;
                    if (dec_enter4)
                    begin
                        nxt_addr4 = 1'b1; // RQ17
                        nxt_state = sfr_pkg::SFR_IDLE;
                    end
                    else if (dec_exit4)
                    begin
                        nxt_addr4 = 1'b0; // RQ17
                        nxt_state = sfr_pkg::SFR_IDLE;
                    end
                    else if (dec_valid)
                    begin
                        nxt_state = sfr_pkg::SFR_ADDR;
                    end
                    else
                    begin
                        // Unsupported opcode: park until select rises
                        nxt_state = sfr_pkg::SFR_DECODE;
                    end
                end
                sfr_pkg::SFR_ADDR:
                begin
                    // Rising edges only, unless the address runs double rate
                    if (rise || (dec_addr_ddr && fall))
                    begin
                        nxt_addr_sr = a_next; // RQ12
                        nxt_cnt     = a_cnt;
                        if (a_cnt == dec_abits)
                        begin
                            nxt_rd_sfdp = dec_sfdp;
                            nxt_rd_addr = dec_sfdp ? {19'h0_0000, a_next[7:0]} : a_next[`SFR_ARRAY_AW-1:0];
                            nxt_cnt     = 6'h00;
                            nxt_bit     = 3'h0;
                            nxt_state   = (dummy_need == 6'h00) ? sfr_pkg::SFR_DATA : sfr_pkg::SFR_DUMMY;
                        end
                    end
                end
                sfr_pkg::SFR_DUMMY:
                begin
                    nxt_oe_n = `SFR_OE_OFF; // RQ22
                    if (rise)
                    begin
                        nxt_cnt = cnt_ff + 6'h01; // RQ22
                        if (cnt_ff + 6'h01 == dummy_need)
                        begin
                            nxt_state = sfr_pkg::SFR_DATA;
                        end
                    end
                end
                sfr_pkg::SFR_DATA:
                begin
                    // Double rate moves a byte on both edges, so bytes go out in pairs
                    if (fall || (dec_data_ddr && rise))
                    begin
                        if (dec_d8)
                        begin
                            nxt_oe_n = `SFR_OE_ALL; // RQ7 RQ8
                            nxt_dq   = cur_byte;
                            adv      = 1'b1; // RQ14
                        end
                        else
                        begin
                            nxt_oe_n   = `SFR_OE_LINE1; // RQ5
                            nxt_dq     = {6'h00, cur_byte[7], 1'b0};
                            nxt_out_sr = {cur_byte[6:0], 1'b0};
                            nxt_bit    = bit_ff + 3'h1;
                            adv        = (bit_ff == 3'h7);
                        end
                    end
                    if (adv)
                    begin
                        nxt_bit = 3'h0;
                        if (rd_sfdp_ff)
                        begin
                            // Table offset rolls at 256 whatever the wrap setting holds
                            nxt_rd_addr = {19'h0_0000, rd_addr_ff[7:0] + 8'h01}; // RQ2 RQ3
                        end
                        else
                        begin
                            nxt_rd_addr = rd_addr_ff + `SFR_ARRAY_AW'(1); // RQ10 RQ11
                        end
                    end
                end
                default:
                begin
                    nxt_state = sfr_pkg::SFR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_ff   <= sfr_pkg::SFR_IDLE;
            sclk_d_ff  <= 1'b0;
            op_ff      <= 8'h00;
            cnt_ff     <= 6'h00;
            addr_sr_ff <= 32'h0000_0000;
            out_sr_ff  <= 8'h00;
            bit_ff     <= 3'h0;
            dq_ff      <= 8'h00;
            oe_n_ff    <= `SFR_OE_OFF;
            rd_addr_ff <= '0;
            rd_sfdp_ff <= 1'b0;
            addr4_ff   <= 1'b0;
            init_ff    <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            sclk_d_ff  <= nxt_sclk_d;
            op_ff      <= nxt_op;
            cnt_ff     <= nxt_cnt;
            addr_sr_ff <= nxt_addr_sr;
            out_sr_ff  <= nxt_out_sr;
            bit_ff     <= nxt_bit;
            dq_ff      <= nxt_dq;
            oe_n_ff    <= nxt_oe_n;
            rd_addr_ff <= nxt_rd_addr;
            rd_sfdp_ff <= nxt_rd_sfdp;
            addr4_ff   <= nxt_addr4;
            init_ff    <= nxt_init;
        end
    end

    assign serial_io_lines_o      = dq_ff;
    assign serial_io_lines_oe_n_o = oe_n_ff;
    assign rd_addr_o              = rd_addr_ff;
    assign rd_sfdp_o              = rd_sfdp_ff;
    assign addr4_mode_o           = addr4_ff;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_decode_ok;
        state_ff == sfr_pkg::SFR_DECODE && dec_valid && !cs_q;
    endsequence

    sequence s_decode_enter;
        state_ff == sfr_pkg::SFR_DECODE && dec_enter4 && !cs_q;
    endsequence

    a_cs_release: assert property (cs_q |=> oe_n_ff == `SFR_OE_OFF && state_ff == sfr_pkg::SFR_IDLE) // RQ4
        else $error("Lines still driven after select rose");

    a_dummy_undriven: assert property (state_ff == sfr_pkg::SFR_DUMMY |-> oe_n_ff == `SFR_OE_OFF) // RQ22
        else $error("Lines driven during dummy clocks");

    a_decode_to_addr: assert property (s_decode_ok |=> state_ff == sfr_pkg::SFR_ADDR && cnt_ff == 6'h00) // RQ5
        else $error("Valid read did not enter address phase");

    a_enter_four: assert property (s_decode_enter |=> addr4_ff && state_ff == sfr_pkg::SFR_IDLE) // RQ17
        else $error("Enter four-byte command not applied");

    a_sfdp_wrap: assert property (adv && rd_sfdp_ff && rd_addr_ff[7:0] == 8'hFF && !cs_q
                                  |=> rd_addr_ff == '0 && rd_sfdp_ff) // RQ2
        else $error("Discovery table did not wrap to zero");

    a_addr_incr: assert property (adv && !rd_sfdp_ff && !cs_q
                                  |=> rd_addr_ff == $past(rd_addr_ff) + `SFR_ARRAY_AW'(1)) // RQ10
        else $error("Read address did not advance by one");

    a_array_wrap: assert property (adv && !rd_sfdp_ff && (&rd_addr_ff) && !cs_q |=> rd_addr_ff == '0) // RQ11
        else $error("Array address did not wrap to zero");

    a_addr_on_rise: assert property (state_ff == sfr_pkg::SFR_ADDR && !dec_addr_ddr && !rise && !cs_q
                                     |=> $stable(addr_sr_ff)) // RQ12
        else $error("Address sampled off a rising edge");

    a_ddr_pairs: assert property (state_ff == sfr_pkg::SFR_DATA && dec_data_ddr && !cs_q && (rise || fall)
                                  |=> oe_n_ff == `SFR_OE_ALL ##[1:2] $stable(rd_addr_ff)) // RQ14
        else $error("Double-rate edge did not move a byte");

    a_fd_form: assert property (state_ff == sfr_pkg::SFR_DECODE && op_ff == `SFR_OP_DDR_OIO
                                |-> dec_abits == `SFR_ABITS4 && dec_a8 && dec_addr_ddr && dec_data_ddr) // RQ18
        else $error("Double-rate octal I/O read misdecoded");

    a_9d_ddr: assert property (state_ff == sfr_pkg::SFR_DECODE && op_ff == `SFR_OP_DDR_OOUT
                               |-> dec_data_ddr && dec_addr_ddr && !dec_a8 == !cfg_octal_ddr_i) // RQ13
        else $error("Double-rate output read not double rate");

    a_sfdp_addr3: assert property (state_ff == sfr_pkg::SFR_DECODE && op_ff == `SFR_OP_SFDP && !cfg_octal_ddr_i
                                   |-> dec_abits == `SFR_ABITS3 && dec_dummy == sfr_pkg::SFR_DUM_EIGHT) // RQ21
        else $error("Discovery read address length wrong");

endmodule : sfr_read_path

`default_nettype wire

// [dv/sfr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] io_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic      [7:0] io_o
);
    logic [7:0] rx [4];
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_o   = 8'h00;
    end
    // Mode bits: eight-line address, double-rate address, eight-line data, double-rate data
    task automatic frame(input logic [63:0] bits, input int ab, input int dm, input int n, input logic [3:0] m);
        int ua;
        int kn;
        int u;
        int d;
        int k;
        bit r;
        bit o;
        ua = m[3] ? ab / 8 : ab;
        kn = m[1] ? n : n * 8;
        u  = 0;
        d  = 0;
        k  = 0;
        cs_n_o <= 1'b0;
        for (int e = 0; u < 8 + ua || d < dm || k < kn; e++)
        begin
            r = (e % 2 == 0);
            o = u == 8 + ua && d == dm && (!r || (m[0] && k > 0));
            // Lines settle mid half period, so a double-rate edge never catches the next unit
            repeat (2) @(posedge core_clk_i);
            if (u < 8 ? r : u < 8 + ua && (r || m[2]))
            begin
                if (u >= 8 && m[3])
                    io_o <= bits[55 - 8 * (u - 8) -: 8];
                else
                    io_o <= {~io_o[7:1], bits[63 - u]};
                u++;
            end
            else if (d < dm && r && u == 8 + ua)
            begin
                // Idle lines toggle so a stale level never passes for data
                io_o <= ~io_o;
                d++;
            end
            repeat (2) @(posedge core_clk_i);
            sclk_o <= r;
            if (o)
            begin
                repeat (7) @(posedge core_clk_i);
                if (m[1])
                    rx[k] = io_i;
                else
                    rx[k / 8][7 - k % 8] = io_i[1];
                k++;
            end
        end
        repeat (4) @(posedge core_clk_i);
        sclk_o <= 1'b0;
        @(posedge core_clk_i);
        cs_n_o <= 1'b1;
        repeat (12) @(posedge core_clk_i);
    endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  dum = 5'h00;
    logic        nv4 = 1'b0;
    logic        sclk, cs_n, sfdp, addr4;
    logic [7:0]  host_io, dut_io, oe_n, bus, rd_data;
    logic [26:0] rd_addr;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    assign bus = (dut_io & ~oe_n) | (host_io & oe_n);
    // Upper address bits feed the data so a dropped carry shows
    assign rd_data = rd_addr[7:0] ^ (sfdp ? 8'hC3 : rd_addr[26:19] ^ 8'h5A);
    sfr_host_model host (.core_clk_i(clk), .io_i(bus), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io));
    sfr_read_path DUT (.core_clk_i(clk), .reset_i(reset), .sclk_i(sclk), .cs_n_i(cs_n),
        .serial_io_lines_i(bus), .serial_io_lines_o(dut_io), .serial_io_lines_oe_n_o(oe_n),
        .cfg_nv_addr4_i(nv4), .cfg_octal_ddr_i(1'b0), .cfg_dummy_i(dum), .rd_addr_o(rd_addr),
        .rd_sfdp_o(sfdp), .rd_data_i(rd_data), .addr4_mode_o(addr4));
    function automatic logic [7:0] mem(input logic [26:0] a, input bit t);
        return t ? a[7:0] ^ 8'hC3 : a[7:0] ^ a[26:19] ^ 8'h5A;
    endfunction : mem
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab, input int dm, input logic [3:0] m,
                      input bit t);
        logic [26:0] nx;
        nx = t ? {19'h0, a[7:0] + 8'h01} : a[26:0] + 27'h1;
        host.frame({op, ab == 32 ? a : {a[23:0], 8'h00}, 24'h0}, ab, dm, 2, m);
        chk("first byte", mem(a[26:0], t), host.rx[0]);
        chk("second byte", mem(nx, t), host.rx[1]);
        chk("line enables", 8'hFF, oe_n);
    endtask : rd
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        rd(8'h03, 32'h00FF_FFFF, 24, 0, 4'h0, 0);
        dum <= 5'h05;
        rd(8'h0B, 32'h0012_3456, 24, 5, 4'h0, 0);
        rd(8'h8B, 32'h0000_ABCD, 24, 5, 4'h2, 0);
        rd(8'h9D, 32'h0031_0A0E, 24, 5, 4'h7, 0);
        rd(8'h13, 32'h07FF_FFFF, 32, 0, 4'h0, 0);
        rd(8'h0C, 32'h0456_7890, 32, 5, 4'h0, 0);
        rd(8'h7C, 32'h0135_7900, 32, 5, 4'h2, 0);
        rd(8'hCC, 32'h0000_1234, 32, 5, 4'hA, 0);
        host.frame({8'hB7, 56'h0}, 0, 0, 0, 4'h0);
        chk("four-byte mode", 8'h01, {7'h0, addr4});
        rd(8'h03, 32'h0765_4321, 32, 0, 4'h0, 0);
        rd(8'h5A, 32'h0000_00FF, 24, 8, 4'h0, 1);
        rd(8'hFD, 32'h0246_8ACE, 32, 5, 4'hF, 0);
        host.frame({8'hE9, 56'h0}, 0, 0, 0, 4'h0);
        chk("four-byte mode", 8'h00, {7'h0, addr4});
        nv4   <= 1'b1;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        chk("four-byte mode", 8'h01, {7'h0, addr4});
        rd(8'hCB, 32'h0135_8ACE, 32, 5, 4'hA, 0);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
